// file: smf_pkg.sv
package smf_pkg;
   // ==========================================
   // Register map
   // ==========================================
   localparam logic [7:0]  SMF_CONTROL_OFS      = 8'h00;
   localparam logic [7:0]  SMF_MODE_OFS         = 8'h01;
   localparam logic [7:0]  SMF_ALIGN_OFS        = 8'h02;
   localparam logic [15:0] SMF_RESET_VAL        = 16'h0000;
   // ==========================================
   // Control register fields
   // ==========================================
   localparam int          SMF_CTL_ARM_BIT      = 5;
   localparam logic [15:0] SMF_CTL_WR_MASK      = 16'h003f;
   // ==========================================
   // Mode register fields
   // ==========================================
   localparam int          SMF_MODE_VAL_LSB     = 5;
   localparam int          SMF_MODE_GO_BIT      = 4;
   localparam int          SMF_MODE_STBY_BIT    = 3;
   localparam int          SMF_MODE_EVAL_BIT    = 2;
   localparam int          SMF_MODE_RATE_LSB    = 0;
   localparam logic [15:0] SMF_MODE_WR_MASK     = 16'h03ff;
   // ==========================================
   // Alignment status fields
   // ==========================================
   localparam int          SMF_ALIGN_DONE_BIT   = 12;
   localparam int          SMF_ALIGN_PHASE_BIT  = 11;
   // ==========================================
   // Connection memory word layout
   // ==========================================
   localparam int          SMF_CM_VAL_LSB       = 11;
   localparam int          SMF_CM_ADDR_W        = 11;
   localparam int          SMF_CM_DATA_W        = 16;
   localparam int          SMF_FILL_W           = 5;
   localparam int          SMF_OFFSET_W         = 11;
   // ==========================================
   // Timing
   // ==========================================
   localparam int          SMF_CLK_MHZ          = 250;
   localparam int          SMF_FRAME_NS         = 125000;
   localparam int          SMF_FRAME_CYC        = SMF_FRAME_NS * SMF_CLK_MHZ / 1000;
   localparam int          SMF_FILL_LIMIT_CYC   = 2 * SMF_FRAME_CYC;

   typedef enum logic [1:0] {
      SMF_RATE_2M   = 2'b00,
      SMF_RATE_4M   = 2'b01,
      SMF_RATE_8M   = 2'b10,
      SMF_RATE_RSVD = 2'b11
   } smf_rate_t;

   typedef enum logic [1:0] {
      SMF_EV_IDLE = 2'b00,
      SMF_EV_RUN  = 2'b01,
      SMF_EV_DONE = 2'b10
   } smf_eval_state_t;
endpackage

// file: smf_block_fill.sv
`timescale 1ns/10ps
module smf_block_fill
   import smf_pkg::*;
#(
   parameter int ADDR_W = SMF_CM_ADDR_W
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     clk_en,
   input  wire logic                     start,
   input  wire logic                     abort,
   input  wire logic [SMF_FILL_W-1:0]    fill_value,
   output logic                          busy,
   output logic                          finished,
   output logic                          cm_wr_en,
   output logic [ADDR_W-1:0]             cm_addr,
   output logic [SMF_CM_DATA_W-1:0]      cm_wdata
);
   logic [ADDR_W-1:0] addr_r;

   // ==========================================
   // Sweep over every connection memory word
   // ==========================================
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy     <= 1'b0;
         finished <= 1'b0;
         addr_r   <= '0;
         cm_wr_en <= 1'b0;
         cm_addr  <= '0;
         cm_wdata <= '0;
      end else if (clk_en) begin
         finished <= 1'b0;
         cm_wr_en <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
         end else if (start && !busy) begin
            busy   <= 1'b1;
            addr_r <= '0;
            cm_wdata <= {fill_value, {SMF_CM_VAL_LSB{1'b0}}};
         end else if (busy) begin
            // One word per cycle finishes far inside two frames.
            cm_wr_en <= 1'b1;
            cm_addr  <= addr_r;
            addr_r   <= addr_r + 1'b1;
            if (addr_r == {ADDR_W{1'b1}}) begin
               busy     <= 1'b0;
               finished <= 1'b1;
            end
         end
      end
   end
endmodule

// file: smf_ctl.sv
`timescale 1ns/10ps
module smf_ctl
   import smf_pkg::*;
#(
   parameter int ADDR_W = SMF_CM_ADDR_W,
   parameter int LANES  = 16
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     clk_en,
   input  wire logic                     cs_n,
   input  wire logic                     ds_n,
   input  wire logic                     rd_wr,
   input  wire logic [7:0]               addr,
   input  wire logic [15:0]              data_in,
   output logic      [15:0]              data_out,
   output logic                          data_oe,
   output logic                          dtack_n,
   input  wire logic                     output_drive_pin,
   input  wire logic                     frame_pulse_in,
   input  wire logic                     master_clk_level,
   input  wire logic                     gci_mode,
   output logic      [LANES-1:0]         serial_out_lanes_oe,
   output logic      [1:0]               rate_select,
   output logic                          cm_wr_en,
   output logic      [ADDR_W-1:0]        cm_addr,
   output logic      [SMF_CM_DATA_W-1:0] cm_wdata
);
   // ==========================================
   // Pin synchronisers
   // ==========================================
   logic [5:0] meta_r;
   logic [5:0] sync_r;
   logic       ds_n_d_r;
   logic       frame_d_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // Strobes reset inactive high, frame pulse at its idle high level, and the others low.
         // A low drive pin bit here keeps the lanes off after reset.
         meta_r    <= 6'h34;
         sync_r    <= 6'h34;
         ds_n_d_r  <= 1'b1;
         frame_d_r <= 1'b1;
      end else if (clk_en) begin
         meta_r    <= {cs_n, ds_n, output_drive_pin, frame_pulse_in, master_clk_level, gci_mode};
         sync_r    <= meta_r;
         ds_n_d_r  <= sync_r[4];
         frame_d_r <= sync_r[2];
      end
   end

   logic cs_n_s;
   logic ds_n_s;
   logic drive_s;
   logic frame_s;
   logic mclk_s;
   logic gci_s;
   assign {cs_n_s, ds_n_s, drive_s, frame_s, mclk_s, gci_s} = sync_r;

   // Address and data are stable while the strobe is low, so they are taken at the synced strobe edge.
   logic access;
   logic wr_ctl;
   logic wr_mode;
   assign access  = ds_n_d_r && !ds_n_s && !cs_n_s;
   assign wr_ctl  = access && !rd_wr && (addr == SMF_CONTROL_OFS);
   assign wr_mode = access && !rd_wr && (addr == SMF_MODE_OFS);

   // ==========================================
   // Registers
   // ==========================================
   logic [15:0] control_r;
   logic [15:0] interface_mode_reg_r;
   logic [15:0] frame_align_reg_r;
   logic        fill_busy;
   logic        fill_finished;
   logic        go_prev_r;
   logic        eval_prev_r;

   logic go_new;
   logic arm_new;
   assign go_new  = wr_mode ? data_in[SMF_MODE_GO_BIT] : interface_mode_reg_r[SMF_MODE_GO_BIT];
   assign arm_new = wr_ctl ? data_in[SMF_CTL_ARM_BIT] : control_r[SMF_CTL_ARM_BIT];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         control_r <= SMF_RESET_VAL;
      end else if (clk_en && wr_ctl) begin
         control_r <= data_in & SMF_CTL_WR_MASK;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interface_mode_reg_r <= SMF_RESET_VAL;
      end else if (clk_en) begin
         if (wr_mode) begin
            interface_mode_reg_r <= data_in & SMF_MODE_WR_MASK;
         end else if (fill_finished) begin
            interface_mode_reg_r[SMF_MODE_GO_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         go_prev_r   <= 1'b0;
         eval_prev_r <= 1'b0;
      end else if (clk_en) begin
         go_prev_r   <= interface_mode_reg_r[SMF_MODE_GO_BIT];
         eval_prev_r <= interface_mode_reg_r[SMF_MODE_EVAL_BIT];
      end
   end

   // ==========================================
   // Block fill
   // ==========================================
   logic fill_start;
   logic fill_abort;
   assign fill_start = interface_mode_reg_r[SMF_MODE_GO_BIT] && !go_prev_r
                       && control_r[SMF_CTL_ARM_BIT];
   assign fill_abort = fill_busy && (!go_new || !arm_new);

   smf_block_fill #(
      .ADDR_W (ADDR_W)
   ) u_fill (
      .clk        (clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .start      (fill_start),
      .abort      (fill_abort),
      .fill_value (interface_mode_reg_r[SMF_MODE_VAL_LSB +: SMF_FILL_W]),
      .busy       (fill_busy),
      .finished   (fill_finished),
      .cm_wr_en   (cm_wr_en),
      .cm_addr    (cm_addr),
      .cm_wdata   (cm_wdata)
   );

   // ==========================================
   // Frame alignment measurement
   // ==========================================
   smf_eval_state_t         ev_state_r;
   logic [SMF_OFFSET_W-1:0] ev_count_r;
   logic                    frame_edge;
   logic                    eval_rise;
   logic                    eval_fall;
   assign frame_edge = gci_s ? (frame_s && !frame_d_r) : (!frame_s && frame_d_r);
   assign eval_rise  = interface_mode_reg_r[SMF_MODE_EVAL_BIT] && !eval_prev_r;
   assign eval_fall  = !interface_mode_reg_r[SMF_MODE_EVAL_BIT] && eval_prev_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ev_state_r        <= SMF_EV_IDLE;
         ev_count_r        <= '0;
         frame_align_reg_r <= SMF_RESET_VAL;
      end else if (clk_en) begin
         case (ev_state_r)
            SMF_EV_IDLE: begin
               if (eval_rise) begin
                  ev_state_r <= SMF_EV_RUN;
                  ev_count_r <= '0;
               end
            end
            SMF_EV_RUN: begin
               if (eval_fall) begin
                  ev_state_r <= SMF_EV_IDLE;
               end else if (frame_edge) begin
                  ev_state_r <= SMF_EV_DONE;
                  frame_align_reg_r <= SMF_RESET_VAL;
                  frame_align_reg_r[SMF_ALIGN_DONE_BIT]  <= 1'b1;
                  frame_align_reg_r[SMF_ALIGN_PHASE_BIT] <= mclk_s;
                  frame_align_reg_r[SMF_OFFSET_W-1:0]    <= ev_count_r;
               end else if (ev_count_r != {SMF_OFFSET_W{1'b1}}) begin
                  ev_count_r <= ev_count_r + 1'b1;
               end
            end
            SMF_EV_DONE: begin
               if (eval_fall) begin
                  ev_state_r <= SMF_EV_IDLE;
                  frame_align_reg_r[SMF_ALIGN_DONE_BIT] <= 1'b0;
               end
            end
            default: begin
               ev_state_r <= SMF_EV_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Read path and outputs
   // ==========================================
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= '0;
         data_oe  <= 1'b0;
         dtack_n  <= 1'b1;
      end else if (clk_en) begin
         if (ds_n_s || cs_n_s) begin
            data_oe <= 1'b0;
            dtack_n <= 1'b1;
         end else if (access) begin
            dtack_n <= 1'b0;
            data_oe <= rd_wr;
            case (addr)
               SMF_CONTROL_OFS: data_out <= control_r;
               SMF_MODE_OFS:    data_out <= interface_mode_reg_r;
               SMF_ALIGN_OFS:   data_out <= frame_align_reg_r;
               default:         data_out <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_out_lanes_oe <= '0;
         rate_select         <= SMF_RATE_2M;
      end else if (clk_en) begin
         serial_out_lanes_oe <= {LANES{drive_s | interface_mode_reg_r[SMF_MODE_STBY_BIT]}};
         rate_select         <= interface_mode_reg_r[SMF_MODE_RATE_LSB +: 2];
      end
   end
endmodule

// file: smf_ctl_checker.sv
`timescale 1ns/10ps
module smf_ctl_checker
   import smf_pkg::*;
#(
   parameter int ADDR_W = SMF_CM_ADDR_W,
   parameter int LANES  = 16
) (
   input wire logic                     clk,
   input wire logic                     reset_n,
   input wire logic                     rd_wr,
   input wire logic [7:0]               addr,
   input wire logic [15:0]              data_in,
   input wire logic [15:0]              data_out,
   input wire logic                     data_oe,
   input wire logic                     dtack_n,
   input wire logic                     output_drive_pin,
   input wire logic [LANES-1:0]         serial_out_lanes_oe,
   input wire logic                     cm_wr_en,
   input wire logic [ADDR_W-1:0]        cm_addr,
   input wire logic [SMF_CM_DATA_W-1:0] cm_wdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Length of the current unbroken run of memory writes.
   int unsigned run_r;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) run_r <= 0;
      else run_r <= cm_wr_en ? run_r + 1 : 0;
   sequence s_step;
      cm_wr_en && $past(cm_wr_en);
   endsequence
   sequence s_abort;
      $fell(dtack_n) && !rd_wr && addr == SMF_MODE_OFS && !data_in[SMF_MODE_GO_BIT];
   endsequence
   property p_low; cm_wr_en |-> cm_wdata[10:0] == 11'h000; endproperty
   property p_val; s_step |-> $stable(cm_wdata); endproperty
   property p_inc; s_step |-> cm_addr == $past(cm_addr) + 1'b1; endproperty
   property p_first; $rose(cm_wr_en) |-> cm_addr == '0; endproperty
   property p_bound; run_r <= 2048; endproperty
   property p_cause; $rose(cm_wr_en) |-> !$past(dtack_n, 2) && !$past(rd_wr, 2); endproperty
   property p_abort; s_abort |-> ##[1:4] !cm_wr_en [*8]; endproperty
   property p_same; serial_out_lanes_oe == '0 || serial_out_lanes_oe == '1; endproperty
   property p_pin; output_drive_pin [*4] |-> serial_out_lanes_oe == '1; endproperty
   property p_rdz; $rose(data_oe) && addr == SMF_MODE_OFS |-> data_out[15:10] == 6'h00; endproperty
   a_low: assert property (p_low) else $error("fill word low bits not zero");
   a_val: assert property (p_val) else $error("fill value changed");
   a_inc: assert property (p_inc) else $error("fill address skipped");
   a_first: assert property (p_first) else $error("fill not from word zero");
   a_bound: assert property (p_bound) else $error("fill ran too long");
   a_cause: assert property (p_cause) else $error("fill without write");
   a_abort: assert property (p_abort) else $error("fill not aborted");
   a_same: assert property (p_same) else $error("lanes split");
   a_pin: assert property (p_pin) else $error("lanes off with pin high");
   a_rdz: assert property (p_rdz) else $error("mode upper bits not zero");
endmodule
bind smf_ctl smf_ctl_checker #(.ADDR_W(ADDR_W), .LANES(LANES)) smf_ctl_checker_inst (.clk, .reset_n,
   .rd_wr, .addr, .data_in, .data_out, .data_oe, .dtack_n, .output_drive_pin, .serial_out_lanes_oe,
   .cm_wr_en, .cm_addr, .cm_wdata);

// file: smf_ctl_tb_top.sv
`timescale 1ns/10ps
module smf_ctl_tb_top
   import smf_pkg::*;
;
   logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, cs_n = 1'b1, ds_n = 1'b1, rd_wr = 1'b1;
   logic        output_drive_pin = 1'b0, frame_pulse_in = 1'b1, master_clk_level = 1'b0, gci_mode = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] data_in = 16'h0000, lf = 16'h0059, rd_v, exp_w, data_out, serial_out_lanes_oe, cm_wdata;
   logic        data_oe, dtack_n, cm_wr_en;
   logic [1:0]  rate_select;
   logic [10:0] cm_addr;
   int          errors = 0, tests_run = 0, cyc = 0, nwr = 0, t_ack = 0;
   smf_ctl smf_ctl_inst (.clk, .reset_n, .clk_en, .cs_n, .ds_n, .rd_wr, .addr, .data_in, .data_out,
      .data_oe, .dtack_n, .output_drive_pin, .frame_pulse_in, .master_clk_level, .gci_mode,
      .serial_out_lanes_oe, .rate_select, .cm_wr_en, .cm_addr, .cm_wdata);
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   function automatic logic [15:0] nxt(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [15:0] fill_word(logic [4:0] v);
      return {v, 11'h000};
   endfunction
   task automatic check(logic [15:0] got, logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Watches every memory write for word content and ascending address.
   always @(negedge clk)
      if (cm_wr_en === 1'b1) begin
         check(cm_wdata, exp_w);
         check({5'h00, cm_addr}, nwr[15:0]);
         nwr++;
      end
   task automatic acc(logic rd, logic [7:0] a, logic [15:0] d);
      int n;
      @(posedge clk);
      cs_n <= 1'b0;
      ds_n <= 1'b0;
      rd_wr <= rd;
      addr <= a;
      data_in <= d;
      n = 0;
      do begin @(negedge clk); n++; end while (dtack_n !== 1'b0 && n < 20);
      check({15'h0, dtack_n}, 16'h0000);
      check({15'h0, data_oe}, {15'h0, rd});
      rd_v = data_out;
      t_ack = cyc;
      @(posedge clk);
      cs_n <= 1'b1;
      ds_n <= 1'b1;
      n = 0;
      do begin @(negedge clk); n++; end while (dtack_n !== 1'b1 && n < 20);
      repeat (3) @(posedge clk);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      errors++;
      close_out();
   end
   initial begin
      int d;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, (i == 3) ? 8'h07 : 8'(i), 16'h0000);
         check(rd_v, 16'h0000);
         check(serial_out_lanes_oe, 16'h0000);
      end
      acc(1'b0, SMF_ALIGN_OFS, 16'hffff);
      acc(1'b1, SMF_ALIGN_OFS, 16'h0000);
      check(rd_v, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         acc(1'b0, SMF_MODE_OFS, (lf & 16'h03e8) | 16'(i % 3));
         acc(1'b1, SMF_MODE_OFS, 16'h0000);
         check(rd_v, lf & 16'h03e8 | 16'(i % 3));
         check({14'h0, rate_select}, 16'(i % 3));
         acc(1'b0, SMF_CONTROL_OFS, lf);
         acc(1'b1, SMF_CONTROL_OFS, 16'h0000);
         check(rd_v, lf & 16'h003f);
      end
      $display("test modes done");
      for (int i = 0; i < 4; i++) begin
         output_drive_pin <= i[1];
         acc(1'b0, SMF_MODE_OFS, {12'h0, i[0], 3'h0});
         repeat (4) @(posedge clk);
         @(negedge clk);
         check(serial_out_lanes_oe, (i > 0) ? 16'hffff : 16'h0000);
      end
      $display("test lanes done");
      acc(1'b0, SMF_CONTROL_OFS, 16'h0000);
      acc(1'b0, SMF_MODE_OFS, 16'h0000);
      nwr = 0;
      acc(1'b0, SMF_MODE_OFS, 16'h0010);
      repeat (50) @(posedge clk);
      check(nwr[15:0], 16'h0000);
      for (int j = 0; j < 3; j++) begin
         lf = nxt(lf);
         exp_w = fill_word((j == 0) ? 5'h1f : lf[4:0]);
         acc(1'b0, SMF_MODE_OFS, 16'h0000);
         acc(1'b0, SMF_CONTROL_OFS, 16'h0020);
         nwr = 0;
         acc(1'b0, SMF_MODE_OFS, {6'h0, exp_w[15:11], 5'h10});
         if (j == 0) begin
            repeat (2100) @(posedge clk);
            check(nwr[15:0], 16'h0800);
            acc(1'b1, SMF_MODE_OFS, 16'h0000);
            check(rd_v, {6'h0, exp_w[15:11], 5'h00});
         end else begin
            repeat (100) @(posedge clk);
            if (j == 1)
               acc(1'b0, SMF_MODE_OFS, {6'h0, exp_w[15:11], 5'h00});
            else
               acc(1'b0, SMF_CONTROL_OFS, 16'h0000);
            d = nwr;
            repeat (50) @(posedge clk);
            check(nwr[15:0], d[15:0]);
            check({15'h0, nwr < 2048}, 16'h0001);
            acc(1'b0, SMF_MODE_OFS, {6'h0, exp_w[15:11], 5'h00});
         end
      end
      $display("test fill done");
      for (int g = 0; g < 2; g++) begin
         lf = nxt(lf);
         gci_mode <= g[0];
         frame_pulse_in <= ~g[0];
         master_clk_level <= lf[7];
         acc(1'b0, SMF_MODE_OFS, 16'h0004);
         d = t_ack;
         repeat (30 + lf[5:0]) @(posedge clk);
         frame_pulse_in <= g[0];
         d = cyc - d;
         repeat (10) @(posedge clk);
         frame_pulse_in <= ~g[0];
         repeat (10) @(posedge clk);
         frame_pulse_in <= g[0];
         acc(1'b1, SMF_ALIGN_OFS, 16'h0000);
         check(rd_v & 16'hf800, {3'h0, 1'b1, lf[7], 11'h000});
         check({15'h0, rd_v[10:0] + 2 >= d && rd_v[10:0] <= d + 8}, 16'h0001);
         acc(1'b0, SMF_MODE_OFS, 16'h0000);
         acc(1'b1, SMF_ALIGN_OFS, 16'h0000);
         check(rd_v & 16'hf000, 16'h0000);
         repeat (SMF_FRAME_CYC) @(posedge clk);
      end
      $display("test eval done");
      close_out();
   end
endmodule
